//--- core/rf_synth_bias_control_regs.sv
// Purpose: APB register bank for synthesizer test features and RF bias currents.
// Assumes: Calibration results arrive from logic on clk; APB master on clk.
// Notes: No wait state on any transfer; pready, prdata and pslverr are flops.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "rf_bias_consts.svh"

// Functional notes
// - Pump scaling factor, bits 5:0, resets to 0x25 and sets loop bandwidth.
// - Loop-open bit 4: zero keeps the synthesizer loop closed, one opens it.
// - Open-loop DAC value, bits 3:0, drives the DAC only while loop is open.
// - Pump current status, bits 4:0, is read-only and shows the applied setting.
// - Tuning DAC status, bits 3:0, is read-only and shows the applied DAC value.
// - Oscillator array status, bits 3:0, is read-only and reads zero after reset.
// - Oscillator core bias, bits 7:4, picks one of sixteen levels, resets 1100.
// - Local oscillator buffer bias, bits 3:2, resets to 10.
// - Amplifier buffer bias, bits 1:0, resets to 10.
// - Follower bias bit 5 resets to zero and selects low or high current.
// - Low-noise amplifier bias, bits 4:3, resets to 00.
// - Mixer route bit 2 sends the mixer output internally or to the shared pin.
// - Signal-strength bit 1 connects that output to the shared pin.
// - Array and pump status reads return the copy picked by frequency select.
module rf_synth_bias_control_regs (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RFB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Calibration results from the synthesizer
  input wire logic freq_sel,
  input wire rf_bias_pkg::cal_result_t cal_a,
  input wire rf_bias_pkg::cal_result_t cal_b,
  input wire logic [3:0] cal_dac_result,
  // Analog control vectors
  output rf_bias_pkg::analog_ctrl_t ctrl
);
  import rf_bias_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  function automatic logic hit(input logic [`RFB_IDX_W-1:0] idx, input logic [`RFB_IDX_W-1:0] reg_idx);
    return idx == reg_idx;
  endfunction : hit

  logic [7:0] current_ctrl;
  logic [7:0] front_end_ctrl;
  logic [4:0] synth_loop_test_ctrl;
  logic [5:0] synth_pump_scale;
  logic [3:0] osc_array_a;
  logic [3:0] osc_array_b;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and transfer phases.

  wire [`RFB_IDX_W-1:0] idx = paddr[`RFB_ADDR_W-1:2];
  wire setup = psel && !penable && !pready;
  wire wr_take = psel && penable && pready && pwrite;
  wire sel_current = hit(idx, `RFB_IDX_CURRENT);
  wire sel_front_end_ctrl = hit(idx, `RFB_IDX_FRONT_END_CTRL);
  wire sel_osc = hit(idx, `RFB_IDX_OSC_ARRAY);
  wire sel_dac = hit(idx, `RFB_IDX_CAL_DAC);
  wire sel_pump = hit(idx, `RFB_IDX_PUMP);
  wire sel_loop = hit(idx, `RFB_IDX_LOOP);
  wire sel_scale = hit(idx, `RFB_IDX_SCALE);
  wire mapped = sel_current || sel_front_end_ctrl || sel_osc || sel_dac || sel_pump || sel_loop || sel_scale;

  // Status registers are read-only; only these four accept writes.
  wire wr_current = wr_take && sel_current;
  wire wr_front_end_ctrl = wr_take && sel_front_end_ctrl;
  wire wr_loop = wr_take && sel_loop;
  wire wr_scale = wr_take && sel_scale;

  //////////////////////////////////////////////////////////////////////////////
  // Read selection.

  wire [3:0] osc_view = freq_sel ? osc_array_b : osc_array_a;
  wire [4:0] pump_view = freq_sel ? cal_b.pump_current : cal_a.pump_current;
  wire [7:0] rd_osc = {4'h0, osc_view};
  wire [7:0] rd_dac = {4'h0, ctrl.cal_dac};
  wire [7:0] rd_pump = {3'h0, pump_view};
  wire [7:0] rd_loop = {3'h0, synth_loop_test_ctrl};
  wire [7:0] rd_scale = {2'h0, synth_pump_scale};
  wire [7:0] rd_byte = sel_current ? current_ctrl :
                       sel_front_end_ctrl ? front_end_ctrl :
                       sel_osc ? rd_osc :
                       sel_dac ? rd_dac :
                       sel_pump ? rd_pump :
                       sel_loop ? rd_loop :
                       sel_scale ? rd_scale : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // APB answer; the setup cycle registers data and error for the access phase.

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Writable registers.

  always_ff @(posedge clk) begin
    if (!resetn) begin
      current_ctrl <= `RFB_RST_CURRENT;
      front_end_ctrl <= `RFB_RST_FRONT_END_CTRL;
      synth_loop_test_ctrl <= `RFB_RST_LOOP;
      synth_pump_scale <= `RFB_RST_SCALE;
    end else if (ce) begin
      if (wr_current) begin
        current_ctrl <= pwdata[`RFB_F_BYTE];
      end
      if (wr_front_end_ctrl) begin
        front_end_ctrl <= pwdata[`RFB_F_BYTE];
      end
      if (wr_loop) begin
        synth_loop_test_ctrl <= pwdata[`RFB_F_LOOP_BITS];
      end
      if (wr_scale) begin
        synth_pump_scale <= pwdata[`RFB_F_SCALE];
      end
    end
  end

  // The array result is held in flops so it reads zero until the first enabled clock after reset.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      osc_array_a <= `RFB_RST_OSC;
      osc_array_b <= `RFB_RST_OSC;
    end else if (ce) begin
      osc_array_a <= cal_a.osc_array;
      osc_array_b <= cal_b.osc_array;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Analog control vectors, one flop stage after the stored registers and the calibrated DAC input.

  wire loop_open = synth_loop_test_ctrl[`RFB_F_LOOP_OPEN];
  wire [3:0] next_cal_dac = loop_open ? synth_loop_test_ctrl[`RFB_F_OPEN_DAC] : cal_dac_result;

  analog_ctrl_t next_ctrl;
  assign next_ctrl.pump_scale_factor = synth_pump_scale;
  assign next_ctrl.loop_open = loop_open;
  assign next_ctrl.cal_dac = next_cal_dac;
  assign next_ctrl.osc_core_bias_sel = current_ctrl[`RFB_F_OSC_BIAS];
  assign next_ctrl.local_osc_buffer_bias = current_ctrl[`RFB_F_LO_BUF];
  assign next_ctrl.amp_buffer_bias = current_ctrl[`RFB_F_AMP_BUF];
  assign next_ctrl.amp_follower_stage = front_end_ctrl[`RFB_F_FOLLOW];
  assign next_ctrl.low_noise_amp_bias = front_end_ctrl[`RFB_F_LNA];
  assign next_ctrl.mixer_to_pin = front_end_ctrl[`RFB_F_MIXER];
  assign next_ctrl.signal_strength_to_pin = front_end_ctrl[`RFB_F_RSSI];

  // Reset values of the control vector mirror the register reset values.
  wire analog_ctrl_t rst_ctrl = '{
    pump_scale_factor: `RFB_RST_SCALE,
    loop_open: 1'b0,
    cal_dac: `RFB_RST_DAC,
    osc_core_bias_sel: `RFB_RST_OSC_BIAS,
    local_osc_buffer_bias: `RFB_RST_LO_BUF,
    amp_buffer_bias: `RFB_RST_AMP_BUF,
    amp_follower_stage: 1'b0,
    low_noise_amp_bias: 2'h0,
    mixer_to_pin: 1'b0,
    signal_strength_to_pin: 1'b0
  };

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl <= rst_ctrl;
    end else if (ce) begin
      ctrl <= next_ctrl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_setup_ce;
    setup && ce;
  endsequence

  sequence s_read_scale;
    setup && ce && !pwrite && sel_scale;
  endsequence

  sequence s_read_osc_b;
    setup && ce && !pwrite && sel_osc && freq_sel;
  endsequence

  sequence s_read_pump;
    setup && ce && !pwrite && sel_pump;
  endsequence

  sequence s_read_dac;
    setup && ce && !pwrite && sel_dac;
  endsequence

  sequence s_read_loop;
    setup && ce && !pwrite && sel_loop;
  endsequence

  // The answer stands for the access cycle only, or a back-to-back master would take it twice.
  sequence s_answer_pulse;
    pready ##1 !pready;
  endsequence

  chk_scale_reset: assert property (@(posedge clk) !resetn |=> synth_pump_scale == `RFB_RST_SCALE)
    else $error("pump scale did not reset to its default");

  chk_loop_reset: assert property (@(posedge clk)
      !resetn |=> !ctrl.loop_open && synth_loop_test_ctrl == `RFB_RST_LOOP)
    else $error("loop test register reset wrong");

  chk_array_reset: assert property (@(posedge clk)
      !resetn |=> osc_array_a == `RFB_RST_OSC && osc_array_b == `RFB_RST_OSC)
    else $error("array status copies did not reset to zero");

  chk_open_dac_use: assert property (@(posedge clk) disable iff (!resetn)
      ce && loop_open |=> ctrl.cal_dac == $past(synth_loop_test_ctrl[`RFB_F_OPEN_DAC]))
    else $error("open-loop DAC value not applied");

  chk_closed_dac_use: assert property (@(posedge clk) disable iff (!resetn)
      ce && !loop_open |=> ctrl.cal_dac == $past(cal_dac_result))
    else $error("calibrated DAC value not applied");

  chk_osc_copy_sel: assert property (@(posedge clk) disable iff (!resetn)
      s_read_osc_b |=> pready && prdata[7:0] == {4'h0, $past(osc_array_b)})
    else $error("array status read did not return copy B");

  chk_pump_copy_sel: assert property (@(posedge clk) disable iff (!resetn)
      s_read_pump |=> prdata[7:0] == {3'h0, ($past(freq_sel) ? $past(cal_b.pump_current)
                                                            : $past(cal_a.pump_current))})
    else $error("pump status read did not return the selected copy");

  chk_dac_status_read: assert property (@(posedge clk) disable iff (!resetn)
      s_read_dac |=> prdata == {28'h000_0000, $past(ctrl.cal_dac)})
    else $error("DAC status read does not show the applied value");

  chk_scale_upper_zero: assert property (@(posedge clk) disable iff (!resetn)
      s_read_scale |=> pready && prdata[7:6] == 2'h0 && prdata[5:0] == $past(synth_pump_scale))
    else $error("pump scale read wrong");

  chk_loop_upper_zero: assert property (@(posedge clk) disable iff (!resetn)
      s_read_loop |=> prdata[7:5] == 3'h0 && prdata[4:0] == $past(synth_loop_test_ctrl))
    else $error("loop test read wrong");

  chk_apb_answer: assert property (@(posedge clk) disable iff (!resetn)
      s_setup_ce |=> s_answer_pulse)
    else $error("APB answer not one cycle after setup");

  chk_unmapped_error: assert property (@(posedge clk) disable iff (!resetn)
      (s_setup_ce and !mapped) |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not flagged");

  chk_scale_follow: assert property (@(posedge clk) disable iff (!resetn)
      ce |=> ctrl.pump_scale_factor == $past(synth_pump_scale))
    else $error("pump scale output does not follow register");

  chk_loop_follow: assert property (@(posedge clk) disable iff (!resetn)
      ce |=> ctrl.loop_open == $past(synth_loop_test_ctrl[`RFB_F_LOOP_OPEN]))
    else $error("loop-open output does not follow register");

  chk_bias_follow: assert property (@(posedge clk) disable iff (!resetn)
      ce |=> ctrl.osc_core_bias_sel == $past(current_ctrl[`RFB_F_OSC_BIAS]))
    else $error("core bias output does not follow register");

  chk_lo_buf_follow: assert property (@(posedge clk) disable iff (!resetn)
      ce |=> ctrl.local_osc_buffer_bias == $past(current_ctrl[`RFB_F_LO_BUF]))
    else $error("oscillator buffer bias output does not follow register");

  chk_follower_bias: assert property (@(posedge clk) disable iff (!resetn)
      ce |=> ctrl.amp_follower_stage == $past(front_end_ctrl[`RFB_F_FOLLOW]))
    else $error("follower bias output does not follow register");

  chk_lna_bias: assert property (@(posedge clk) disable iff (!resetn)
      ce |=> ctrl.low_noise_amp_bias == $past(front_end_ctrl[`RFB_F_LNA]))
    else $error("low-noise amplifier bias output does not follow register");

  chk_pin_route: assert property (@(posedge clk) disable iff (!resetn)
      ce |=> ctrl.mixer_to_pin == $past(front_end_ctrl[`RFB_F_MIXER])
             && ctrl.signal_strength_to_pin == $past(front_end_ctrl[`RFB_F_RSSI]))
    else $error("shared pin routing does not follow register");

  chk_write_current: assert property (@(posedge clk) disable iff (!resetn)
      ce && wr_current |=> current_ctrl == $past(pwdata[`RFB_F_BYTE])
        ##1 ctrl.amp_buffer_bias == current_ctrl[`RFB_F_AMP_BUF])
    else $error("current control write not applied");

  chk_status_ro: assert property (@(posedge clk) disable iff (!resetn)
      ce && wr_take && (sel_pump || sel_osc || sel_dac) |=> $stable(current_ctrl) && $stable(synth_pump_scale))
    else $error("write to status register changed state");

  chk_ce_freeze: assert property (@(posedge clk) disable iff (!resetn)
      !ce |=> $stable(ctrl) && $stable(pready) && $stable(prdata) && $stable(current_ctrl))
    else $error("state moved while clock enable was low");

endmodule : rf_synth_bias_control_regs

//--- core/rf_bias_consts.svh
// Purpose: Register indices, reset values and field positions of the synthesizer and bias register bank.
// Assumes: Byte address of a register is four times its index.
// Notes: Field macros expand to bit ranges or single bit positions for use inside a part-select or bit-select.
`ifndef RF_BIAS_CONSTS_SVH
`define RF_BIAS_CONSTS_SVH

`define RFB_ADDR_W 10
`define RFB_IDX_W 8
`define RFB_IDX_CURRENT 8'hE1
`define RFB_IDX_FRONT_END_CTRL 8'hEE
`define RFB_IDX_OSC_ARRAY 8'hF9
`define RFB_IDX_CAL_DAC 8'hFA
`define RFB_IDX_PUMP 8'hFB
`define RFB_IDX_LOOP 8'hFC
`define RFB_IDX_SCALE 8'hFD

`define RFB_RST_CURRENT 8'hCA
`define RFB_RST_FRONT_END_CTRL 8'h00
`define RFB_RST_LOOP 5'h04
`define RFB_RST_SCALE 6'h25
`define RFB_RST_OSC 4'h0
`define RFB_RST_DAC 4'h0
`define RFB_RST_PUMP 5'h00
`define RFB_RST_OSC_BIAS 4'hC
`define RFB_RST_LO_BUF 2'h2
`define RFB_RST_AMP_BUF 2'h2

`define RFB_F_OSC_BIAS 7:4
`define RFB_F_LO_BUF 3:2
`define RFB_F_AMP_BUF 1:0
`define RFB_F_FOLLOW 5
`define RFB_F_LNA 4:3
`define RFB_F_MIXER 2
`define RFB_F_RSSI 1
`define RFB_F_LOOP_OPEN 4
`define RFB_F_OPEN_DAC 3:0
`define RFB_F_LOOP_BITS 4:0
`define RFB_F_SCALE 5:0
`define RFB_F_PUMP 4:0
`define RFB_F_NIBBLE 3:0
`define RFB_F_BYTE 7:0

`endif

//--- core/rf_bias_pkg.sv
// Purpose: Types shared by the synthesizer and bias register bank and its neighbours.
// Assumes: Nothing beyond the constants header.
// Notes: Structs carry the calibration results in and the analog controls out.
package rf_bias_pkg;

  typedef struct packed {
    logic [3:0] osc_array;
    logic [4:0] pump_current;
  } cal_result_t;

  typedef struct packed {
    logic [5:0] pump_scale_factor;
    logic loop_open;
    logic [3:0] cal_dac;
    logic [3:0] osc_core_bias_sel;
    logic [1:0] local_osc_buffer_bias;
    logic [1:0] amp_buffer_bias;
    logic amp_follower_stage;
    logic [1:0] low_noise_amp_bias;
    logic mixer_to_pin;
    logic signal_strength_to_pin;
  } analog_ctrl_t;

endpackage : rf_bias_pkg

//--- bench/rf_synth_bias_control_regs_bench.sv
// Purpose: Self-checking bench for the synthesizer and bias register bank.
// Assumes: Each APB transfer answers within the apb task's 50-poll limit; ce held high except for the freeze check.
// Notes: Table rows cover writes and reads; reset, DAC handover and copy select follow by hand.
`timescale 1ns/1ps
`include "rf_bias_consts.svh"
module rf_synth_bias_control_regs_bench;
  import rf_bias_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [31:0] exp;
    logic err;
  } row_t;
  logic clk, resetn, ce, psel, penable, pwrite, pready, pslverr, freq_sel, er;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] cal_dac_result;
  cal_result_t cal_a, cal_b;
  analog_ctrl_t ctrl, e;
  int err_count, checked;
  row_t rows [14] = '{
    '{1'b1, `RFB_IDX_CURRENT, 8'h46, 32'h0, 1'b0}, '{1'b0, `RFB_IDX_CURRENT, 8'h0, 32'h46, 1'b0},
    '{1'b1, `RFB_IDX_FRONT_END_CTRL, 8'h3E, 32'h0, 1'b0}, '{1'b0, `RFB_IDX_FRONT_END_CTRL, 8'h0, 32'h3E, 1'b0},
    '{1'b1, `RFB_IDX_SCALE, 8'hFF, 32'h0, 1'b0}, '{1'b0, `RFB_IDX_SCALE, 8'h0, 32'h3F, 1'b0},
    '{1'b1, `RFB_IDX_LOOP, 8'hFA, 32'h0, 1'b0}, '{1'b0, `RFB_IDX_LOOP, 8'h0, 32'h1A, 1'b0},
    '{1'b1, `RFB_IDX_OSC_ARRAY, 8'hFF, 32'h0, 1'b0}, '{1'b0, `RFB_IDX_OSC_ARRAY, 8'h0, 32'h09, 1'b0},
    '{1'b1, `RFB_IDX_PUMP, 8'hFF, 32'h0, 1'b0}, '{1'b0, `RFB_IDX_PUMP, 8'h0, 32'h11, 1'b0},
    '{1'b1, 8'h80, 8'h55, 32'h0, 1'b1}, '{1'b0, 8'h80, 8'h0, 32'h0, 1'b1}
  };
  logic [7:0] ridx [5] = '{`RFB_IDX_CURRENT, `RFB_IDX_FRONT_END_CTRL, `RFB_IDX_LOOP, `RFB_IDX_SCALE, `RFB_IDX_OSC_ARRAY};
  logic [31:0] rval [5] = '{32'hCA, 32'h00, 32'h04, 32'h25, 32'h00};

  rf_synth_bias_control_regs uut (
    .clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .freq_sel(freq_sel), .cal_a(cal_a), .cal_b(cal_b), .cal_dac_result(cal_dac_result), .ctrl(ctrl)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // The request is held until pready is seen, so no slave latency is assumed.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rdv, output logic erv);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) begin
      err_count++;
    end
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic stop_test();
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    stop_test();
  end

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 10'h000;
    pwdata = 32'h0;
    freq_sel = 1'b0;
    cal_a = '{4'h9, 5'h11};
    cal_b = '{4'h6, 5'h0A};
    cal_dac_result = 4'h3;
    err_count = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].idx, rows[i].wd, rd, er);
      chk({31'h0, er}, {31'h0, rows[i].err});
      if (!rows[i].wr) begin
        chk(rd, rows[i].exp);
      end
    end
    e = '{6'h3F, 1'b1, 4'hA, 4'h4, 2'h1, 2'h2, 1'b1, 2'h3, 1'b1, 1'b1};
    chk({4'h0, ctrl}, {4'h0, e});
    apb(1'b0, `RFB_IDX_CAL_DAC, 8'h0, rd, er);
    chk(rd, 32'h0A);
    // Closing the loop hands the DAC back to calibration one cycle after the write lands.
    apb(1'b1, `RFB_IDX_LOOP, 8'h05, rd, er);
    @(posedge clk);
    #1;
    chk({27'h0, ctrl.loop_open, ctrl.cal_dac}, {27'h0, 1'b0, 4'h3});
    apb(1'b0, `RFB_IDX_CAL_DAC, 8'h0, rd, er);
    chk(rd, 32'h03);
    // With ce low the control vector must hold although the calibrated value moves on.
    ce <= 1'b0;
    cal_dac_result <= 4'h7;
    repeat (3) @(posedge clk);
    #1;
    chk({28'h0, ctrl.cal_dac}, 32'h3);
    @(posedge clk);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    cal_dac_result <= 4'h3;
    #1;
    chk({28'h0, ctrl.cal_dac}, 32'h7);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      freq_sel <= s[0];
      apb(1'b0, `RFB_IDX_OSC_ARRAY, 8'h0, rd, er);
      chk(rd, s ? 32'h06 : 32'h09);
      apb(1'b0, `RFB_IDX_PUMP, 8'h0, rd, er);
      chk(rd, s ? 32'h0A : 32'h11);
    end
    // A second reset in mid-run must restore every modified field.
    @(posedge clk);
    resetn <= 1'b0;
    cal_a <= '0;
    cal_b <= '0;
    freq_sel <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    e = '{6'h25, 1'b0, 4'h3, 4'hC, 2'h2, 2'h2, 1'b0, 2'h0, 1'b0, 1'b0};
    chk({4'h0, ctrl}, {4'h0, e});
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ridx[i], 8'h0, rd, er);
      chk(rd, rval[i]);
    end
    stop_test();
  end
endmodule : rf_synth_bias_control_regs_bench
